// ===== design/lcbcw_top.sv
// Command word register, interrupt gating and command dispatch.
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module lcbcw_top
  import lcbcw_pkg::*;
#(
  parameter int AW = 12
) (
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire logic          ce_i,
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [AW-1:0] paddr_i,
  input  wire logic [31:0]   pwdata_i,
  input  wire logic [3:0]    pstrb_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  input  wire logic [5:0]    irq_flags_i,
  input  wire logic          swi_flag_i,
  output logic               swi_set_o,
  output logic               inta_n_o,
  input  wire logic [31:0]   gen_pointer_i,
  input  wire logic          list_done_i,
  input  wire logic          list_suspend_i,
  output logic      [1:0]    cu_state_o,
  output logic      [31:0]   list_addr_o,
  output logic               list_begin_o,
  output logic               list_next_o,
  output logic      [2:0]    ru_opcode_o,
  output logic               ru_cmd_o
);

  // ---------------------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------------------

  logic [15:0] cmd_q, cmd_d;
  logic        swi_q;
  logic        inta_q;
  logic        ru_cmd_q;
  logic [1:0]  wr_lanes;
  logic [15:0] rd_cmd;
  logic [15:0] rd_stat;

  lcbcw_apb_slave #(
    .AW (AW)
  ) u_apb (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .psel_i     (psel_i),
    .penable_i  (penable_i),
    .pwrite_i   (pwrite_i),
    .paddr_i    (paddr_i),
    .pstrb_i    (pstrb_i),
    .rd_cmd_i   (rd_cmd),
    .rd_stat_i  (rd_stat),
    .prdata_o   (prdata_o),
    .pready_o   (pready_o),
    .pslverr_o  (pslverr_o),
    .wr_lanes_o (wr_lanes)
  );

  // ---------------------------------------------------------------------------
  // Command word register
  // ---------------------------------------------------------------------------

  wire        wr_lo    = wr_lanes[0];
  wire        wr_hi    = wr_lanes[1];
  wire        swi_wr   = wr_hi & pwdata_i[`LCBCW_SWI_BIT];
  wire        cuc_wr   = wr_lo;
  wire [3:0]  cuc_code = pwdata_i[`LCBCW_CUC_HI:`LCBCW_CUC_LO];
  wire [5:0]  masks    = cmd_q[`LCBCW_MASK_HI:`LCBCW_MASK_LO];
  wire        gmask    = cmd_q[`LCBCW_GMASK_BIT];

  // The software interrupt bit is never stored; it reads as zero.
  always_comb begin
    cmd_d = cmd_q;
    if (wr_hi) begin
      cmd_d[`LCBCW_MASK_HI:`LCBCW_GMASK_BIT] =
        pwdata_i[`LCBCW_MASK_HI:`LCBCW_GMASK_BIT];
      cmd_d[`LCBCW_SWI_BIT] = 1'b0;
    end
    if (wr_lo) begin
      cmd_d[`LCBCW_CUC_HI:`LCBCW_RUC_LO] =
        pwdata_i[`LCBCW_CUC_HI:`LCBCW_RUC_LO];
      cmd_d[`LCBCW_RSVD_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_q    <= `LCBCW_CMD_RESET;
      swi_q    <= 1'b0;
      ru_cmd_q <= 1'b0;
    end else if (ce_i) begin
      cmd_q    <= cmd_d;
      swi_q    <= swi_wr;
      ru_cmd_q <= wr_lo;
    end
  end

  assign rd_cmd      = cmd_q;
  assign ru_opcode_o = cmd_q[`LCBCW_RUC_HI:`LCBCW_RUC_LO];
  assign ru_cmd_o    = ru_cmd_q;
  assign swi_set_o   = swi_q;

  // ---------------------------------------------------------------------------
  // Interrupt pin gating
  // ---------------------------------------------------------------------------

  wire [5:0] cause_live = irq_flags_i & ~masks;
  wire       any_cause  = (|cause_live) | swi_flag_i;
  wire       raise      = any_cause & ~gmask;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      inta_q <= 1'b0;
    end else if (ce_i) begin
      inta_q <= raise;
    end
  end

  assign inta_n_o = ~inta_q;

  // ---------------------------------------------------------------------------
  // Command unit
  // ---------------------------------------------------------------------------

  lcbcw_cu_fsm u_cu (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .cmd_valid_i (cuc_wr),
    .cmd_code_i  (cuc_code),
    .pointer_i   (gen_pointer_i),
    .done_i      (list_done_i),
    .suspend_i   (list_suspend_i),
    .state_o     (cu_state_o),
    .addr_o      (list_addr_o),
    .begin_o     (list_begin_o),
    .next_o      (list_next_o)
  );

  // Status word: unit state, pending flags and pin state.
  assign rd_stat = {6'h00, inta_q, swi_flag_i, irq_flags_i, cu_state_o};

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------

  chk_reset_zero: assert property (
    @(posedge clk_i) reset_i |=> (cmd_q == `LCBCW_CMD_RESET) && inta_n_o
  ) else $error("Command word not cleared by reset.");

  chk_global_block: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && gmask) |=> inta_n_o
  ) else $error("Interrupt pin asserted under global mask.");

  chk_cause_raise: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && !gmask && ((irq_flags_i & ~masks) != 6'h00)) |=> !inta_n_o
  ) else $error("Unmasked cause did not assert the interrupt pin.");

  chk_cause_quiet: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && ((irq_flags_i & ~masks) == 6'h00) && !swi_flag_i) |=> inta_n_o
  ) else $error("Masked cause asserted the interrupt pin.");

  chk_swi_pulse: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && psel_i && penable_i && pwrite_i && pstrb_i[1]
      && paddr_i == AW'(`LCBCW_CMD_ADDR) && pwdata_i[`LCBCW_SWI_BIT])
      |=> swi_set_o ##1 (!swi_set_o || !ce_i || $past(swi_wr))
  ) else $error("Software interrupt request not raised for one cycle.");

  chk_swi_readzero: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !cmd_q[`LCBCW_SWI_BIT]
  ) else $error("Write-only software interrupt bit is stored.");

  chk_nop_hold: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (cuc_wr && cuc_code != `LCBCW_CUC_BEGIN
      && cuc_code != `LCBCW_CUC_CONTINUE && !list_done_i && !list_suspend_i)
      |=> $stable(cu_state_o) && !list_begin_o && !list_next_o
  ) else $error("Inert opcode changed command unit state.");

  chk_begin_load: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (cuc_wr && cuc_code == `LCBCW_CUC_BEGIN && !cu_state_o[1])
      |=> list_begin_o && (list_addr_o == $past(gen_pointer_i))
          && (cu_state_o == `LCBCW_CU_LPQ)
  ) else $error("Begin did not start the list at the pointer.");

  chk_cont_idle: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (cuc_wr && cuc_code == `LCBCW_CUC_CONTINUE
      && cu_state_o == `LCBCW_CU_IDLE)
      |=> !list_next_o && (cu_state_o == `LCBCW_CU_IDLE)
  ) else $error("Continue acted on an idle command unit.");

  chk_cont_susp: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (cuc_wr && cuc_code == `LCBCW_CUC_CONTINUE
      && cu_state_o == `LCBCW_CU_SUSP)
      |=> list_next_o && (cu_state_o == `LCBCW_CU_LPQ) ##1 !list_next_o
  ) else $error("Continue did not resume a suspended command unit.");

  chk_state_code: assert property (
    @(posedge clk_i) disable iff (reset_i)
    cu_state_o != `LCBCW_CU_HPQ
  ) else $error("Command unit reported an unused state code.");

  chk_apb_unmapped: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (psel_i && penable_i && paddr_i != AW'(`LCBCW_CMD_ADDR)
      && paddr_i != AW'(`LCBCW_STAT_ADDR)) |-> pslverr_o
  ) else $error("Unmapped address answered without error.");

  // ---------------------------------------------------------------------------
  // Register storage checks
  // ---------------------------------------------------------------------------

  chk_mask_store: assert property (
    @(posedge clk_i) disable iff (reset_i)
    wr_hi |=> masks == $past(pwdata_i[`LCBCW_MASK_HI:`LCBCW_MASK_LO])
  ) else $error("Mask bits not stored from the high byte.");

  chk_gmask_store: assert property (
    @(posedge clk_i) disable iff (reset_i)
    wr_hi |=> gmask == $past(pwdata_i[`LCBCW_GMASK_BIT])
  ) else $error("Global mask not stored from the high byte.");

  chk_opcode_store: assert property (
    @(posedge clk_i) disable iff (reset_i)
    wr_lo |=> cmd_q[`LCBCW_CUC_HI:`LCBCW_CUC_LO] == $past(cuc_code)
  ) else $error("Command unit opcode not stored.");

  chk_rsvd_zero: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !cmd_q[`LCBCW_RSVD_BIT]
  ) else $error("Reserved command word bit is stored.");

  chk_cmd_hold: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && !wr_hi && !wr_lo) |=> $stable(cmd_q)
  ) else $error("Command word changed without a write.");

  chk_status_ro: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (psel_i && penable_i && pwrite_i
      && paddr_i == AW'(`LCBCW_STAT_ADDR)) |=> $stable(cmd_q)
  ) else $error("Status write changed the command word.");

  chk_lane_gate: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (wr_hi || wr_lo) |-> (psel_i && penable_i && pwrite_i
      && paddr_i == AW'(`LCBCW_CMD_ADDR))
  ) else $error("Write lane enabled outside a command word write.");

  chk_freeze_all: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !ce_i |=> $stable(cmd_q) && $stable(inta_n_o) && $stable(cu_state_o)
      && $stable(swi_set_o)
  ) else $error("State changed while the clock enable was low.");

  chk_ready_ce: assert property (
    @(posedge clk_i) disable iff (reset_i)
    pready_o == ce_i
  ) else $error("Ready does not follow the clock enable.");

  // ---------------------------------------------------------------------------
  // Software interrupt checks
  // ---------------------------------------------------------------------------

  chk_swi_quiet: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && !swi_wr) |=> !swi_set_o
  ) else $error("Software interrupt raised without a write of one.");

  chk_swi_raise: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && !gmask && swi_flag_i) |=> !inta_n_o
  ) else $error("Pending software interrupt did not assert the pin.");

  chk_swi_blocked: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && gmask && swi_flag_i) |=> inta_n_o
  ) else $error("Software interrupt passed the global mask.");

  // ---------------------------------------------------------------------------
  // Command unit and receive unit command checks
  // ---------------------------------------------------------------------------

  chk_begin_busy: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (cuc_wr && cuc_code == `LCBCW_CUC_BEGIN
      && cu_state_o == `LCBCW_CU_LPQ) |=> !list_begin_o
  ) else $error("Begin acted on an active command unit.");

  chk_begin_quiet: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && !(cuc_wr && cuc_code == `LCBCW_CUC_BEGIN)) |=> !list_begin_o
  ) else $error("List start pulse without a begin opcode.");

  chk_next_quiet: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && !(cuc_wr && cuc_code == `LCBCW_CUC_CONTINUE)) |=> !list_next_o
  ) else $error("Next block pulse without a continue opcode.");

  chk_addr_hold: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && !(cuc_wr && cuc_code == `LCBCW_CUC_BEGIN))
      |=> $stable(list_addr_o)
  ) else $error("List address changed without a begin opcode.");

  chk_done_idle: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cu_state_o == `LCBCW_CU_LPQ && list_done_i)
      |=> cu_state_o == `LCBCW_CU_IDLE
  ) else $error("Finished list did not return to idle.");

  chk_susp_entry: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cu_state_o == `LCBCW_CU_LPQ && !list_done_i && list_suspend_i)
      |=> cu_state_o == `LCBCW_CU_SUSP
  ) else $error("Suspend request did not suspend the command unit.");

  chk_idle_hold: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cu_state_o == `LCBCW_CU_IDLE && !cuc_wr)
      |=> cu_state_o == `LCBCW_CU_IDLE
  ) else $error("Idle command unit left idle without a command.");

  chk_ru_quiet: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && !wr_lo) |=> !ru_cmd_o
  ) else $error("Receive command pulse without a low byte write.");

  chk_ru_pulse: assert property (
    @(posedge clk_i) disable iff (reset_i)
    wr_lo |=> ru_cmd_o
  ) else $error("Low byte write gave no receive command pulse.");

endmodule : lcbcw_top
`default_nettype wire

// ===== design/lcbcw_map.svh
// Register map, field positions, codes and reset values of the command word.
// -----------------------------------------------------------------------------
// Summary of operation
// - Sixteen-bit command word, offset 02h, resets zero.
// - Software writes commands and interrupt masks through it.
// - Bit 15 masks the block-executed interrupt.
// - Bit 14 masks the frame-received interrupt.
// - Bit 13 masks the unit-not-active interrupt.
// - Bit 12 masks the receiver-not-ready interrupt.
// - Bit 11 masks the early-receive interrupt.
// - Bit 10 masks the pause-frame interrupt.
// - Bit 9 write-only; one raises software interrupt.
// - Bit 8 set never asserts the interrupt pin.
// - Global mask overrides cause masks and software interrupt.
// - No-operation code leaves command unit unchanged.
// - Begin code starts list at general pointer.
// - Code 0010 continues next block; ignored when idle.
// - Command unit opcode sits in bits 7 to 4.
// - Unit state codes idle 00, suspended 01, active 1x.
// -----------------------------------------------------------------------------
`ifndef LCBCW_MAP_SVH
`define LCBCW_MAP_SVH

`define LCBCW_CMD_INDEX    12'h002
`define LCBCW_CMD_ADDR     12'h008
`define LCBCW_STAT_ADDR    12'h00c
`define LCBCW_CMD_RESET    16'h0000
`define LCBCW_MASK_HI      15
`define LCBCW_MASK_LO      10
`define LCBCW_SWI_BIT      9
`define LCBCW_GMASK_BIT    8
`define LCBCW_CUC_HI       7
`define LCBCW_CUC_LO       4
`define LCBCW_RUC_HI       2
`define LCBCW_RUC_LO       0
`define LCBCW_CUC_NOP      4'h0
`define LCBCW_CUC_BEGIN    4'h1
`define LCBCW_CUC_CONTINUE 4'h2
`define LCBCW_CU_IDLE      2'h0
`define LCBCW_CU_SUSP      2'h1
`define LCBCW_CU_LPQ       2'h2
`define LCBCW_CU_HPQ       2'h3
`define LCBCW_RSVD_BIT     3

`endif

// ===== design/lcbcw_pkg.sv
// Types shared by the command word block.
`include "lcbcw_map.svh"
package lcbcw_pkg;

  typedef enum logic [1:0] {
    CU_IDLE,
    CU_SUSPENDED,
    CU_ACTIVE
  } lcbcw_cu_state_type;

  function automatic logic [1:0] lcbcw_cu_code(input lcbcw_cu_state_type s);
    case (s)
      CU_IDLE:      lcbcw_cu_code = `LCBCW_CU_IDLE;
      CU_SUSPENDED: lcbcw_cu_code = `LCBCW_CU_SUSP;
      CU_ACTIVE:    lcbcw_cu_code = `LCBCW_CU_LPQ;
      default:      lcbcw_cu_code = `LCBCW_CU_IDLE;
    endcase
  endfunction : lcbcw_cu_code

endpackage : lcbcw_pkg

// ===== design/lcbcw_apb_slave.sv
// APB slave front end with registered read data.
`timescale 1ns/100ps
`default_nettype none
module lcbcw_apb_slave
  import lcbcw_pkg::*;
#(
  parameter int AW = 12
) (
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire logic          ce_i,
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [AW-1:0] paddr_i,
  input  wire logic [3:0]    pstrb_i,
  input  wire logic [15:0]   rd_cmd_i,
  input  wire logic [15:0]   rd_stat_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  output logic      [1:0]    wr_lanes_o
);

  logic [31:0] prdata_q;
  wire         hit_cmd  = (paddr_i == AW'(`LCBCW_CMD_ADDR));
  wire         hit_stat = (paddr_i == AW'(`LCBCW_STAT_ADDR));
  wire         hit      = hit_cmd | hit_stat;
  wire         access   = psel_i & penable_i & ce_i;
  wire         setup    = psel_i & ~penable_i;
  wire [15:0]  rd_word  = hit_cmd ? rd_cmd_i : (hit_stat ? rd_stat_i : 16'h0000);

  assign pready_o   = ce_i;
  assign pslverr_o  = psel_i & penable_i & ~hit;
  assign wr_lanes_o = (access & pwrite_i & hit_cmd) ? pstrb_i[1:0] : 2'b00;
  assign prdata_o   = prdata_q;

  // Read data is captured during the setup cycle.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (ce_i && setup) begin
      prdata_q <= {16'h0000, rd_word};
    end
  end

endmodule : lcbcw_apb_slave
`default_nettype wire

// ===== design/lcbcw_cu_fsm.sv
// Command unit state tracking: idle, suspended and active.
`timescale 1ns/100ps
`default_nettype none
module lcbcw_cu_fsm
  import lcbcw_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [3:0]  cmd_code_i,
  input  wire logic [31:0] pointer_i,
  input  wire logic        done_i,
  input  wire logic        suspend_i,
  output logic      [1:0]  state_o,
  output logic      [31:0] addr_o,
  output logic             begin_o,
  output logic             next_o
);

  lcbcw_cu_state_type state_q, state_d;
  logic [31:0]        addr_q;
  logic               begin_q, next_q;

  wire is_begin = cmd_valid_i & (cmd_code_i == `LCBCW_CUC_BEGIN);
  wire is_cont  = cmd_valid_i & (cmd_code_i == `LCBCW_CUC_CONTINUE);
  wire do_begin = is_begin & (state_q != CU_ACTIVE);
  wire do_cont  = is_cont & (state_q == CU_SUSPENDED);

  // Other codes, including no-operation, fall through unchanged.
  always_comb begin
    state_d = state_q;
    case (state_q)
      CU_IDLE:      if (do_begin) state_d = CU_ACTIVE;
      CU_SUSPENDED: if (do_begin || do_cont) state_d = CU_ACTIVE;
      CU_ACTIVE: begin
        if (done_i) state_d = CU_IDLE;
        else if (suspend_i) state_d = CU_SUSPENDED;
      end
      default:      state_d = CU_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= CU_IDLE;
      addr_q  <= 32'h0000_0000;
      begin_q <= 1'b0;
      next_q  <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      begin_q <= do_begin;
      next_q  <= do_cont;
      if (do_begin) addr_q <= pointer_i;
    end
  end

  assign state_o = lcbcw_cu_code(state_q);
  assign addr_o  = addr_q;
  assign begin_o = begin_q;
  assign next_o  = next_q;

endmodule : lcbcw_cu_fsm
`default_nettype wire

// ===== verification/lcbcw_top_tb.sv
// Self-checking testbench for the command word block.
`timescale 1ns/100ps
`default_nettype none
`include "lcbcw_map.svh"
module lcbcw_top_tb;
  // ----------------------------------------------------------------------
  // Stimulus signals and counters
  // ----------------------------------------------------------------------
  logic        clk_i, reset_i, ce_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, gen_pointer_i, list_addr_o;
  logic [3:0]  pstrb_i;
  logic        pready_o, pslverr_o, swi_flag_i, swi_set_o, inta_n_o;
  logic [5:0]  irq_flags_i;
  logic        list_done_i, list_suspend_i, list_begin_o, list_next_o;
  logic [1:0]  cu_state_o;
  logic [2:0]  ru_opcode_o;
  logic        ru_cmd_o;
  int          n_errors, checks_done, n_begin, n_next, n_swi, n_ru;
  logic [31:0] rd;
  logic        err;

  lcbcw_top #(.AW(12)) lcbcw_top_inst (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_flags_i(irq_flags_i),
    .swi_flag_i(swi_flag_i), .swi_set_o(swi_set_o), .inta_n_o(inta_n_o),
    .gen_pointer_i(gen_pointer_i), .list_done_i(list_done_i),
    .list_suspend_i(list_suspend_i), .cu_state_o(cu_state_o),
    .list_addr_o(list_addr_o), .list_begin_o(list_begin_o),
    .list_next_o(list_next_o), .ru_opcode_o(ru_opcode_o),
    .ru_cmd_o(ru_cmd_o));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (list_begin_o === 1'b1) n_begin++;
    if (list_next_o === 1'b1) n_next++;
    if (swi_set_o === 1'b1) n_swi++;
    if (ru_cmd_o === 1'b1) n_ru++;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    psel_i   <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && k < 50) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 50) n_errors++;
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic finish_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset();
    apb(1'b0, `LCBCW_CMD_ADDR, 32'h0);
    check(rd, 32'h0000_0000);
    check(err, 1'b0);
    check(inta_n_o, 1'b1);
    check(cu_state_o, 2'h0);
  endtask : test_reset

  task automatic test_masks();
    for (int i = 0; i < 6; i++) begin
      irq_flags_i <= 6'h01 << i;
      apb(1'b1, `LCBCW_CMD_ADDR, 32'h0000_fc00 & ~(32'h400 << i));
      tick(3);
      check(inta_n_o, 1'b0);
      apb(1'b1, `LCBCW_CMD_ADDR, 32'h400 << i);
      tick(3);
      check(inta_n_o, 1'b1);
    end
  endtask : test_masks

  task automatic test_swi_global();
    int s, r;
    s = n_swi;
    r = n_ru;
    irq_flags_i <= 6'h3f;
    apb(1'b1, `LCBCW_CMD_ADDR, 32'h0000_ffff);
    tick(3);
    check(n_swi - s, 1);
    check(n_ru - r, 1);
    check(ru_opcode_o, 32'h7);
    swi_flag_i <= 1'b1;
    tick(3);
    check(inta_n_o, 1'b1);
    apb(1'b0, `LCBCW_CMD_ADDR, 32'h0);
    check(rd, 32'h0000_fdf7);
    check(cu_state_o, 2'h0);
    irq_flags_i <= 6'h00;
    apb(1'b1, `LCBCW_CMD_ADDR, 32'h0000_fc00);
    tick(3);
    check(inta_n_o, 1'b0);
    check(n_swi - s, 1);
    swi_flag_i <= 1'b0;
    apb(1'b1, `LCBCW_CMD_ADDR, 32'h0000_0000);
  endtask : test_swi_global

  task automatic test_cu();
    int b, n;
    b = n_begin;
    n = n_next;
    gen_pointer_i <= 32'h1234_5678;
    apb(1'b1, `LCBCW_CMD_ADDR, 32'h0000_0000);
    tick(2);
    check(cu_state_o, 2'h0);
    apb(1'b1, `LCBCW_CMD_ADDR, 32'h0000_0020);
    tick(2);
    check(n_next - n, 0);
    check(cu_state_o, 2'h0);
    apb(1'b1, `LCBCW_CMD_ADDR, 32'h0000_0010);
    tick(2);
    check(n_begin - b, 1);
    check(list_addr_o, 32'h1234_5678);
    check(cu_state_o, 2'h2);
    apb(1'b0, `LCBCW_STAT_ADDR, 32'h0);
    check(rd, 32'h0000_0002);
    apb(1'b1, `LCBCW_CMD_ADDR, 32'h0000_0050);
    tick(2);
    check(cu_state_o, 2'h2);
    list_suspend_i <= 1'b1;
    tick(1);
    list_suspend_i <= 1'b0;
    tick(2);
    check(cu_state_o, 2'h1);
    apb(1'b1, `LCBCW_CMD_ADDR, 32'h0000_0000);
    tick(2);
    check(cu_state_o, 2'h1);
    apb(1'b1, `LCBCW_CMD_ADDR, 32'h0000_0020);
    tick(2);
    check(n_next - n, 1);
    check(cu_state_o, 2'h2);
    list_done_i <= 1'b1;
    tick(1);
    list_done_i <= 1'b0;
    tick(2);
    check(cu_state_o, 2'h0);
  endtask : test_cu

  task automatic test_unmapped();
    apb(1'b1, 12'h010, 32'h0000_ffff);
    check(err, 1'b1);
    apb(1'b0, `LCBCW_CMD_ADDR, 32'h0);
    check(rd, 32'h0000_0020);
    apb(1'b0, 12'h010, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
  endtask : test_unmapped

  task automatic test_freeze();
    @(posedge clk_i);
    ce_i        <= 1'b0;
    irq_flags_i <= 6'h01;
    tick(3);
    check(inta_n_o, 1'b1);
    @(posedge clk_i);
    ce_i <= 1'b1;
    tick(2);
    check(inta_n_o, 1'b0);
    @(posedge clk_i);
    irq_flags_i <= 6'h00;
    reset_i     <= 1'b1;
    @(posedge clk_i);
    reset_i <= 1'b0;
    apb(1'b0, `LCBCW_CMD_ADDR, 32'h0);
    check(rd, 32'h0000_0000);
    check(inta_n_o, 1'b1);
    check(cu_state_o, 2'h0);
  endtask : test_freeze

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    pstrb_i = 4'hf;
    irq_flags_i = 6'h00;
    swi_flag_i = 1'b0;
    gen_pointer_i = 32'h0;
    list_done_i = 1'b0;
    list_suspend_i = 1'b0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    test_reset();
    test_masks();
    test_swi_global();
    test_cu();
    test_unmapped();
    test_freeze();
    finish_test();
  end

  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
endmodule : lcbcw_top_tb
`default_nettype wire
